// File: pkg/rtc_pkg.sv
// constants, field layouts and carrier types for the rtc value views
// assumes a 10 MHz pclk and a 32-bit apb with 12 address bits
package rtc_pkg;

    // clocking and the one-second tick
    localparam int unsigned    CLK_PERIOD_NS = 100;
    localparam longint unsigned SECOND_NS    = 64'd1000000000;
    localparam int unsigned    SECOND_CYCLES =
        int'(SECOND_NS / longint'(CLK_PERIOD_NS));

    // apb address map, byte addresses
    localparam int unsigned    ADDR_W        = 12;
    localparam logic [11:0]    CTRL_OFS      = 12'h000;
    localparam logic [11:0]    TIME_WIN_OFS  = 12'h004;
    localparam logic [11:0]    ALARM_WIN_OFS = 12'h008;

    // control register layout
    localparam int unsigned    WREN_BIT      = 0;
    localparam int unsigned    TPTR_LSB      = 8;
    localparam int unsigned    APTR_LSB      = 12;
    localparam logic           WREN_RESET    = 1'b0;
    localparam logic [1:0]     PTR_RESET     = 2'h0;

    // window pointer codes
    localparam logic [1:0]     PTR_MINSEC    = 2'h0;
    localparam logic [1:0]     PTR_WDHR      = 2'h1;
    localparam logic [1:0]     PTR_MDAY      = 2'h2;

    // digit field positions inside the 16-bit views
    localparam int unsigned    WEEKDAY_LSB   = 8;
    localparam int unsigned    HRT_LSB       = 4;
    localparam int unsigned    HRO_LSB       = 0;
    localparam int unsigned    MINT_LSB      = 12;
    localparam int unsigned    MINO_LSB      = 8;
    localparam int unsigned    SECT_LSB      = 4;
    localparam int unsigned    SECO_LSB      = 0;
    localparam int unsigned    MTHT_BIT      = 12;
    localparam int unsigned    MTHO_LSB      = 8;
    localparam int unsigned    DAYT_LSB      = 4;
    localparam int unsigned    DAYO_LSB      = 0;

    // implemented bits of each view
    localparam logic [15:0]    WDHR_MASK     = 16'h073F;
    localparam logic [15:0]    MINSEC_MASK   = 16'h7F7F;
    localparam logic [15:0]    MDAY_MASK     = 16'h1F3F;

    // rollover limits
    localparam logic [3:0]     ONES_LAST     = 4'h9;
    localparam logic [2:0]     TENS60_LAST   = 3'h5;
    localparam logic [1:0]     HOUR_T_LAST   = 2'h2;
    localparam logic [3:0]     HOUR_O_LAST   = 4'h3;
    localparam logic [2:0]     WEEKDAY_LAST  = 3'h6;

    typedef struct packed {
        logic [2:0] weekday_digit;
        logic [1:0] hour_tens_digit;
        logic [3:0] hour_ones_digit;
        logic [2:0] minute_tens_digit;
        logic [3:0] minute_ones_digit;
        logic [2:0] second_tens_digit;
        logic [3:0] second_ones_digit;
    } clock_time_t;

    typedef struct packed {
        logic       month_tens_bit;
        logic [3:0] month_ones_digit;
        logic [1:0] calendar_day_tens_digit;
        logic [3:0] calendar_day_ones_digit;
    } alarm_date_t;

endpackage

// File: core/second_divider.sv
// divider that turns pclk into a one-cycle enable once per period
// assumes pclk is the only clock and presetn is asynchronous active low
`timescale 1ns/1ps
module second_divider #(
    parameter int unsigned PERIOD = 10
) (
    input  wire logic pclk,
    input  wire logic presetn,
    output logic      tick
);
    import rtc_pkg::*;

    logic [31:0] count_q;
    logic        tick_q;

    // free-running count, wraps after period cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= 32'h0000_0000;
        end else if (count_q == 32'(PERIOD - 1)) begin
            count_q <= 32'h0000_0000;
        end else begin
            count_q <= count_q + 32'h0000_0001;
        end
    end

    // one-cycle pulse at the wrap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= (count_q == 32'(PERIOD - 1));
        end
    end

    assign tick = tick_q;
endmodule

// File: core/rtc_value_views.sv
// bcd time and alarm value views of a real-time clock, apb slave
// assumes pclk at 10 MHz, presetn asynchronous active low, apb master
//
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ps
module rtc_value_views #(
    parameter int unsigned SECOND_TICKS = rtc_pkg::SECOND_CYCLES
) (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [rtc_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]               pwdata,
    input  wire logic [3:0]                pstrb,
    output logic                           pready,
    output logic [31:0]                    prdata,
    output logic                           pslverr
);
    import rtc_pkg::*;

    logic        sec_tick;
    logic        wren_q;
    logic [1:0]  tptr_q;
    logic [1:0]  aptr_q;
    clock_time_t time_q;
    clock_time_t time_d;
    clock_time_t alarm_time_q;
    clock_time_t alarm_time_d;
    alarm_date_t alarm_date_q;
    alarm_date_t alarm_date_d;
    logic [31:0] prdata_q;
    logic [15:0] time_view;
    logic [15:0] alarm_view;
    logic        setup;
    logic        access;
    logic        sel_ctrl;
    logic        sel_time;
    logic        sel_alarm;
    logic        upper_touch;
    logic        time_wr;
    logic        alarm_wr;

    // packs the weekday and hour digits into their view
    function automatic logic [15:0] pack_wdhr(input clock_time_t t);
        logic [15:0] v;
        v = 16'h0000;
        v[WEEKDAY_LSB +: 3] = t.weekday_digit;
        v[HRT_LSB +: 2]  = t.hour_tens_digit;
        v[HRO_LSB +: 4]  = t.hour_ones_digit;
        return v;
    endfunction

    // packs the minute and second digits into their view
    function automatic logic [15:0] pack_minsec(input clock_time_t t);
        logic [15:0] v;
        v = 16'h0000;
        v[MINT_LSB +: 3] = t.minute_tens_digit;
        v[MINO_LSB +: 4] = t.minute_ones_digit;
        v[SECT_LSB +: 3] = t.second_tens_digit;
        v[SECO_LSB +: 4] = t.second_ones_digit;
        return v;
    endfunction

    // loads the weekday and hour digits from a view
    function automatic clock_time_t unpack_wdhr(input clock_time_t t,
                                                input logic [15:0] v);
        clock_time_t r;
        r = t;
        r.weekday_digit   = v[WEEKDAY_LSB +: 3];
        r.hour_tens_digit = v[HRT_LSB +: 2];
        r.hour_ones_digit = v[HRO_LSB +: 4];
        return r;
    endfunction

    // loads the minute and second digits from a view
    function automatic clock_time_t unpack_minsec(input clock_time_t t,
                                                  input logic [15:0] v);
        clock_time_t r;
        r = t;
        r.minute_tens_digit = v[MINT_LSB +: 3];
        r.minute_ones_digit = v[MINO_LSB +: 4];
        r.second_tens_digit = v[SECT_LSB +: 3];
        r.second_ones_digit = v[SECO_LSB +: 4];
        return r;
    endfunction

    // byte-lane merge of a write, unimplemented bits forced to zero
    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [15:0] wd,
                                          input logic [1:0]  strb,
                                          input logic [15:0] mask);
        logic [15:0] bm;
        bm = {{8{strb[1]}}, {8{strb[0]}}};
        return ((old & ~bm) | (wd & bm)) & mask;
    endfunction

    // one-second step with bcd carries
    function automatic clock_time_t advance(input clock_time_t t);
        clock_time_t r;
        r = t;
        if (t.second_ones_digit != ONES_LAST) begin
            r.second_ones_digit = t.second_ones_digit + 4'h1;
        end else begin
            r.second_ones_digit = 4'h0;
            if (t.second_tens_digit != TENS60_LAST) begin
                r.second_tens_digit = t.second_tens_digit + 3'h1;
            end else begin
                r.second_tens_digit = 3'h0;
                if (t.minute_ones_digit != ONES_LAST) begin
                    r.minute_ones_digit = t.minute_ones_digit + 4'h1;
                end else begin
                    r.minute_ones_digit = 4'h0;
                    if (t.minute_tens_digit != TENS60_LAST) begin
                        r.minute_tens_digit = t.minute_tens_digit + 3'h1;
                    end else begin
                        r.minute_tens_digit = 3'h0;
                        if (t.hour_tens_digit == HOUR_T_LAST &&
                            t.hour_ones_digit == HOUR_O_LAST) begin
                            r.hour_tens_digit = 2'h0;
                            r.hour_ones_digit = 4'h0;
                            r.weekday_digit = (t.weekday_digit == WEEKDAY_LAST)
                                ? 3'h0 : t.weekday_digit + 3'h1;
                        end else if (t.hour_ones_digit == ONES_LAST) begin
                            r.hour_ones_digit = 4'h0;
                            r.hour_tens_digit = t.hour_tens_digit + 2'h1;
                        end else begin
                            r.hour_ones_digit = t.hour_ones_digit + 4'h1;
                        end
                    end
                end
            end
        end
        return r;
    endfunction

    // once-a-second enable
    second_divider #(
        .PERIOD  (SECOND_TICKS)
    ) u_second (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (sec_tick)
    );

    // apb phase and address decode
    assign setup       = psel & ~penable;
    assign access      = psel & penable;
    assign sel_ctrl    = (paddr == CTRL_OFS);
    assign sel_time    = (paddr == TIME_WIN_OFS);
    assign sel_alarm   = (paddr == ALARM_WIN_OFS);
    assign upper_touch = pwrite ? pstrb[1] : 1'b1; // reads touch upper byte
    assign time_wr     = access & pwrite & sel_time & wren_q;
    assign alarm_wr    = access & pwrite & sel_alarm;

    // zero-wait slave, error on unmapped address
    assign pready  = access;
    assign pslverr = access & ~(sel_ctrl | sel_time | sel_alarm);
    assign prdata  = prdata_q;

    // views that each window currently presents
    always_comb begin
        unique case (tptr_q)
            PTR_WDHR:   time_view = pack_wdhr(time_q);
            PTR_MINSEC: time_view = pack_minsec(time_q);
            default:    time_view = 16'h0000;
        endcase
    end

    always_comb begin
        alarm_view = 16'h0000;
        unique case (aptr_q)
            PTR_MDAY: begin
                alarm_view[MTHT_BIT]       = alarm_date_q.month_tens_bit;
                alarm_view[MTHO_LSB +: 4]  = alarm_date_q.month_ones_digit;
                alarm_view[DAYT_LSB +: 2]  =
                    alarm_date_q.calendar_day_tens_digit;
                alarm_view[DAYO_LSB +: 4]  =
                    alarm_date_q.calendar_day_ones_digit;
            end
            PTR_WDHR:   alarm_view = pack_wdhr(alarm_time_q);
            PTR_MINSEC: alarm_view = pack_minsec(alarm_time_q);
            default:    alarm_view = 16'h0000;
        endcase
    end

    // read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup) begin
            prdata_q <= 32'h0000_0000;
            if (sel_ctrl) begin
                prdata_q[WREN_BIT]      <= wren_q;
                prdata_q[TPTR_LSB +: 2] <= tptr_q;
                prdata_q[APTR_LSB +: 2] <= aptr_q;
            end else if (sel_time) begin
                prdata_q[15:0] <= time_view;
            end else if (sel_alarm) begin
                prdata_q[15:0] <= alarm_view;
            end
        end
    end

    // write-enable control
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wren_q <= WREN_RESET;
        end else if (access & pwrite & sel_ctrl & pstrb[0]) begin
            wren_q <= pwdata[WREN_BIT];
        end
    end

    // window pointers: loaded by software, stepped by upper-byte access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tptr_q <= PTR_RESET;
        end else if (access & pwrite & sel_ctrl & pstrb[1]) begin
            tptr_q <= pwdata[TPTR_LSB +: 2];
        end else if (access & sel_time & upper_touch &
                     tptr_q != PTR_MINSEC) begin
            tptr_q <= tptr_q - 2'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aptr_q <= PTR_RESET;
        end else if (access & pwrite & sel_ctrl & pstrb[1]) begin
            aptr_q <= pwdata[APTR_LSB +: 2];
        end else if (access & sel_alarm & upper_touch &
                     aptr_q != PTR_MINSEC) begin
            aptr_q <= aptr_q - 2'h1;
        end
    end

    // running time: tick first, then written bytes override
    always_comb begin
        time_d = sec_tick ? advance(time_q) : time_q;
        if (time_wr && tptr_q == PTR_MINSEC) begin
            time_d = unpack_minsec(time_d, merge(pack_minsec(time_d),
                     pwdata[15:0], pstrb[1:0], MINSEC_MASK));
        end else if (time_wr && tptr_q == PTR_WDHR) begin
            time_d = unpack_wdhr(time_d, merge(pack_wdhr(time_d),
                     pwdata[15:0], pstrb[1:0], WDHR_MASK));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            time_q <= '0;
        end else begin
            time_q <= time_d;
        end
    end

    // alarm views: minsec always writable, the others need write enable
    always_comb begin
        logic [15:0] v;
        v            = 16'h0000;
        alarm_time_d = alarm_time_q;
        alarm_date_d = alarm_date_q;
        if (alarm_wr && aptr_q == PTR_MINSEC) begin
            alarm_time_d = unpack_minsec(alarm_time_q,
                merge(pack_minsec(alarm_time_q), pwdata[15:0], pstrb[1:0],
                      MINSEC_MASK));
        end else if (alarm_wr && wren_q && aptr_q == PTR_WDHR) begin
            alarm_time_d = unpack_wdhr(alarm_time_q,
                merge(pack_wdhr(alarm_time_q), pwdata[15:0], pstrb[1:0],
                      WDHR_MASK));
        end else if (alarm_wr && wren_q && aptr_q == PTR_MDAY) begin
            v = merge(alarm_view, pwdata[15:0], pstrb[1:0], MDAY_MASK);
            alarm_date_d.month_tens_bit          = v[MTHT_BIT];
            alarm_date_d.month_ones_digit        = v[MTHO_LSB +: 4];
            alarm_date_d.calendar_day_tens_digit = v[DAYT_LSB +: 2];
            alarm_date_d.calendar_day_ones_digit = v[DAYO_LSB +: 4];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_time_q <= '0;
            alarm_date_q <= '0;
        end else begin
            alarm_time_q <= alarm_time_d;
            alarm_date_q <= alarm_date_d;
        end
    end

    // checks on the views, the locks, the pointers and the second and day rollovers
    unimpl_zero_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        access && !pwrite && (sel_time || sel_alarm) |->
            prdata[31:16] == 16'h0000 && prdata[15] == 1'b0 &&
            prdata[7] == 1'b0)
        else $error("unimplemented view bits read nonzero");

    time_view_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        setup && sel_time && tptr_q == PTR_WDHR |=>
            prdata[15:0] == $past(time_view) &&
            prdata[15:11] == 5'h00 && prdata[7:6] == 2'h0)
        else $error("time window read does not match its view");

    alarm_view_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        setup && sel_alarm && aptr_q == PTR_MDAY |=>
            prdata[12] == $past(alarm_date_q.month_tens_bit) &&
            prdata[5:4] == $past(alarm_date_q.calendar_day_tens_digit) &&
            prdata[15:13] == 3'h0)
        else $error("alarm month-day view misplaced");

    time_lock_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        access && pwrite && sel_time && !wren_q && !sec_tick |=>
            time_q == $past(time_q))
        else $error("locked time view was written");

    alarm_lock_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        access && pwrite && sel_alarm && !wren_q &&
        aptr_q != PTR_MINSEC |=>
            $stable(alarm_date_q) && $stable(alarm_time_q))
        else $error("locked alarm view was written");

    ptr_step_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        access && sel_time && upper_touch && tptr_q != PTR_MINSEC |=>
            tptr_q == $past(tptr_q) - 2'h1)
        else $error("time pointer did not step down");

    ptr_floor_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        access && sel_alarm && aptr_q == PTR_MINSEC |=>
            (aptr_q == PTR_MINSEC) [*2])
        else $error("alarm pointer moved below zero");

    sec_wrap_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        sec_tick && !time_wr && time_q.second_tens_digit == TENS60_LAST &&
        time_q.second_ones_digit == ONES_LAST |=>
            time_q.second_tens_digit == 3'h0 &&
            time_q.second_ones_digit == 4'h0 &&
            time_q.minute_ones_digit != $past(time_q.minute_ones_digit))
        else $error("seconds did not roll over with carry");

    day_wrap_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        sec_tick && !time_wr && pack_minsec(time_q) == 16'h5959 &&
        time_q.hour_tens_digit == HOUR_T_LAST &&
        time_q.hour_ones_digit == HOUR_O_LAST &&
        time_q.weekday_digit == WEEKDAY_LAST |=>
            pack_wdhr(time_q) == 16'h0000 &&
            pack_minsec(time_q) == 16'h0000)
        else $error("midnight of weekday six did not wrap to zero");
endmodule

// File: sim/tb_rtc_value_views.sv
// testbench for the rtc value views: apb tasks, row table, awkward cases
// assumes rtc_pkg is compiled first and the design is the only apb slave
`timescale 1ns/1ps
module tb_rtc_value_views;
    import rtc_pkg::*;

    localparam int unsigned TICKS = 400;

    typedef struct packed {
        logic        wren;
        logic [1:0]  ptr;
        logic [1:0]  strb;
        logic [15:0] wd;
        logic [15:0] ex;
    } row_t;

    logic              pclk;
    logic              presetn;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
    logic [3:0]        pstrb;
    logic              pready;
    logic [31:0]       prdata;
    logic              pslverr;
    int                mismatches;
    int                checked;
    row_t              rows [0:10];
    logic [31:0]       d;
    logic              e;
    logic [1:0]        p;

    rtc_value_views #(.SECOND_TICKS(TICKS)) rtc_value_views_inst (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .pstrb   (pstrb),
        .pready  (pready),
        .prdata  (prdata),
        .pslverr (pslverr)
    );

    // 100 ns clock
    always #50 pclk = ~pclk;

    // one apb transfer, held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] wd, input logic [3:0] s,
                       output logic [31:0] r, output logic err);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        // wait for the answer; only the watchdog ends a hung transfer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r   = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] wd,
                      input logic [3:0] s);
        logic [31:0] r;
        logic        err;
        apb(1'b1, a, wd, s, r, err);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        logic err;
        apb(1'b0, a, 32'h0000_0000, 4'h0, r, err);
    endtask

    // compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] ex);
        checked++;
        if (got !== ex) begin
            mismatches++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, ex);
        end
    endtask

    // control word: alarm pointer, time pointer, write enable
    function automatic logic [31:0] ctl(input logic [1:0] ap,
                                        input logic [1:0] tp,
                                        input logic w);
        return (32'(ap) << APTR_LSB) | (32'(tp) << TPTR_LSB) | 32'(w);
    endfunction

    task automatic finish_test;
        $display("mismatches %0d checked %0d", mismatches, checked);
        if (mismatches == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // watchdog
    initial begin
        #(100 * 20000);
        mismatches++;
        finish_test();
    end

    // main sequence
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = '0;
        mismatches = 0;
        checked = 0;
        rows = '{
            '{1'b1, 2'h0, 2'h3, 16'hFFFF, 16'h7F7F},
            '{1'b0, 2'h0, 2'h3, 16'h5959, 16'h5959},
            '{1'b1, 2'h1, 2'h3, 16'hFFFF, 16'h073F},
            '{1'b0, 2'h1, 2'h3, 16'h0623, 16'h073F},
            '{1'b1, 2'h1, 2'h3, 16'h0623, 16'h0623},
            '{1'b1, 2'h2, 2'h3, 16'hFFFF, 16'h1F3F},
            '{1'b0, 2'h2, 2'h3, 16'h1231, 16'h1F3F},
            '{1'b1, 2'h2, 2'h1, 16'h0A31, 16'h1F31},
            '{1'b1, 2'h2, 2'h2, 16'h1200, 16'h1231},
            '{1'b1, 2'h1, 2'h1, 16'h0000, 16'h0600},
            '{1'b1, 2'h3, 2'h3, 16'hFFFF, 16'h0000}};
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(CTRL_OFS, d);
        check(d, 32'h0000_0000);
        rd(ALARM_WIN_OFS, d);
        check(d, 32'h0000_0000);
        // alarm window rows: write, pointer step, read back
        for (int i = 0; i <= 10; i++) begin
            wr(CTRL_OFS, ctl(rows[i].ptr, 2'h0, rows[i].wren), 4'hF);
            wr(ALARM_WIN_OFS, {16'h0000, rows[i].wd}, {2'b00, rows[i].strb});
            p = (rows[i].strb[1] && rows[i].ptr != 2'h0) ?
                rows[i].ptr - 2'h1 : rows[i].ptr;
            rd(CTRL_OFS, d);
            check(d, ctl(p, 2'h0, rows[i].wren));
            wr(CTRL_OFS, ctl(rows[i].ptr, 2'h0, rows[i].wren), 4'hF);
            rd(ALARM_WIN_OFS, d);
            check(d, {16'h0000, rows[i].ex});
        end
        // unmapped address
        apb(1'b0, 12'h00C, 32'h0000_0000, 4'h0, d, e);
        check({31'h0, e}, 32'h0000_0001);
        check(d, 32'h0000_0000);
        // locked time window keeps ticking from reset
        wr(CTRL_OFS, ctl(2'h0, 2'h0, 1'b0), 4'hF);
        wr(TIME_WIN_OFS, 32'h0000_5959, 4'h3);
        rd(TIME_WIN_OFS, d);
        check({24'h0, d[15:8]}, 32'h0000_0000);
        // full rollover 6 23:59:59 -> 0 00:00:00
        wr(CTRL_OFS, ctl(2'h0, 2'h1, 1'b1), 4'hF);
        wr(TIME_WIN_OFS, 32'h0000_0623, 4'h3);
        wr(TIME_WIN_OFS, 32'h0000_5959, 4'h3);
        for (int n = 0; n < 300; n++) begin
            rd(TIME_WIN_OFS, d);
            if (d !== 32'h0000_5959) break;
        end
        check(d, 32'h0000_0000);
        wr(CTRL_OFS, ctl(2'h0, 2'h2, 1'b1), 4'hF);
        rd(TIME_WIN_OFS, d);
        check(d, 32'h0000_0000);
        rd(CTRL_OFS, d);
        check(d, ctl(2'h0, 2'h1, 1'b1));
        rd(TIME_WIN_OFS, d);
        check(d, 32'h0000_0000);
        rd(TIME_WIN_OFS, d);
        rd(CTRL_OFS, d);
        check(d, ctl(2'h0, 2'h0, 1'b1));
        // control byte strobes, then a locked weekday-hours write
        wr(CTRL_OFS, ctl(2'h0, 2'h1, 1'b0), 4'h2);
        rd(CTRL_OFS, d);
        check(d, ctl(2'h0, 2'h1, 1'b1));
        wr(CTRL_OFS, 32'h0000_0000, 4'h1);
        wr(TIME_WIN_OFS, 32'h0000_0623, 4'h3);
        rd(CTRL_OFS, d);
        check(d, ctl(2'h0, 2'h0, 1'b0));
        wr(CTRL_OFS, ctl(2'h0, 2'h1, 1'b0), 4'h2);
        rd(TIME_WIN_OFS, d);
        check(d, 32'h0000_0000);
        // second reset in mid-run
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(CTRL_OFS, d);
        check(d, 32'h0000_0000);
        rd(ALARM_WIN_OFS, d);
        check(d, 32'h0000_0000);
        finish_test();
    end
endmodule
